// ### hdl/supervisor_pkg.sv
// constants and carrier types for the supervisor watchdog reset block
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_NS = 20;
  // reset hold period, least 140 ms
  localparam int unsigned HOLD_MS = 140;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  // watchdog timeout period, nominal 1.5 s
  localparam int unsigned WDOG_MS = 1500;
  localparam int unsigned WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
  // internal driver low share, 87.5 percent as seven eighths
  localparam int unsigned DRV_LOW_NUM = 7;
  localparam int unsigned DRV_LOW_DEN = 8;
  // supply dips this long or shorter are ignored
  localparam int unsigned GLITCH_US = 55;
  localparam int unsigned GLITCH_CYC = GLITCH_US * (CLK_HZ / 1000000);
  // shortest kick pulse that must count
  localparam int unsigned KICK_MIN_NS = 50;
  localparam int unsigned KICK_MIN_CYC = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned GLITCH_W = 12;

  typedef struct packed {
    logic supply_low;
    logic manual;
    logic watchdog;
  } reset_cause_s;
endpackage

// ### hdl/supervisor_watchdog_reset.sv
// supervisor: supply, manual and watchdog sources merged into one system reset
// Summary of operation
// (RULE1) supply low asserts reset at variant polarity
// (RULE2) reset held full hold period after supply recovers
// (RULE3) kick pulses of 50ns are registered
// (RULE4) host kicks within watchdog period, 1.5s
// (RULE5) watchdog expiry asserts reset for hold period
// (RULE6) watchdog counter held zero during reset
// (RULE7) counting restarts from zero after reset
// (RULE8) reset or kick transition clears watchdog counter
// (RULE9) internal driver low 87.5% then high
// (RULE10) floating kick serviced by driver, disabling watchdog
// (RULE11) manual reset held, then hold period after release
// (RULE12) unconnected manual reset reads inactive high
// (RULE13) switch bounce yields one reset ending after release
// (RULE14) short supply dips are ignored
// (RULE15) reset during power-up, power-down and brownout
// (RULE16) host may pulse low-high-low within 7/8 period
// (RULE17) host sets and clears kick at separate places
// (RULE18) periods from counters on one clock; variant parameters
`timescale 1ns/1ps
module supervisor_watchdog_reset #(
  parameter int unsigned HOLD_CYCLES = supervisor_pkg::HOLD_CYC,
  parameter int unsigned WDOG_CYCLES = supervisor_pkg::WDOG_CYC,
  parameter bit ACTIVE_HIGH = 1'b0,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_low_i,
  input wire logic manual_reset_n_input_i,
  input wire logic manual_reset_n_input_oe_i,
  input wire logic watchdog_kick_input_i,
  input wire logic watchdog_kick_input_oe_i,
  output logic system_reset_n_output_o,
  output logic system_reset_n_output_oe_o,
  output logic reset_active_o,
  output supervisor_pkg::reset_cause_s cause_o
);
  localparam logic [supervisor_pkg::CNT_W-1:0] HOLD_LAST =
    (supervisor_pkg::CNT_W)'(HOLD_CYCLES - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] WDOG_LAST =
    (supervisor_pkg::CNT_W)'(WDOG_CYCLES - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] DRV_HIGH_AT = (supervisor_pkg::CNT_W)'(
    (WDOG_CYCLES / supervisor_pkg::DRV_LOW_DEN) * supervisor_pkg::DRV_LOW_NUM);
  localparam logic [supervisor_pkg::GLITCH_W-1:0] GLITCH_LAST =
    (supervisor_pkg::GLITCH_W)'(supervisor_pkg::GLITCH_CYC);

  typedef enum logic [1:0] {ST_ACTIVE, ST_HOLD, ST_RUN} state_e;

  // two-flop synchronisers for pins
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] pin_raw;
  logic weak_drive;
  always_comb
  begin
    pin_raw[0] = supply_low_i;
    // pull-up: undriven manual reset reads high
    pin_raw[1] = manual_reset_n_input_oe_i ? manual_reset_n_input_i : 1'b1; // RULE12
    pin_raw[2] = watchdog_kick_input_oe_i ? watchdog_kick_input_i : weak_drive; // RULE10
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  state_e state;
  state_e next_state;
  logic [supervisor_pkg::CNT_W-1:0] hold_cnt;
  logic [supervisor_pkg::CNT_W-1:0] next_hold_cnt;
  logic [supervisor_pkg::CNT_W-1:0] wdog_cnt;
  logic [supervisor_pkg::CNT_W-1:0] next_wdog_cnt;
  logic [supervisor_pkg::CNT_W-1:0] drv_cnt;
  logic [supervisor_pkg::CNT_W-1:0] next_drv_cnt;
  logic [supervisor_pkg::GLITCH_W-1:0] dip_cnt;
  logic [supervisor_pkg::GLITCH_W-1:0] next_dip_cnt;
  logic kick_prev;
  logic next_weak_drive;
  logic supply_low;
  logic kick_edge;
  logic wdog_expire;
  logic hold_cause;
  supervisor_pkg::reset_cause_s cause;
  supervisor_pkg::reset_cause_s next_cause;
  logic rst_out;

  // any kick transition counts; one 20ns sample catches a 50ns pulse
  assign kick_edge = sync2[2] ^ kick_prev; // RULE3
  assign wdog_expire = (state == ST_RUN) && (wdog_cnt == WDOG_LAST); // RULE5
  // dip filter: supply low only after it persists past the window
  assign supply_low = sync2[0] && (dip_cnt == GLITCH_LAST); // RULE14
  assign hold_cause = supply_low || !sync2[1]; // RULE13

  always_comb
  begin
    next_dip_cnt = '0;
    if (sync2[0])
      next_dip_cnt = (dip_cnt == GLITCH_LAST) ? dip_cnt : dip_cnt + 1'b1;
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_cause = cause;
    case (state)
      ST_ACTIVE:
      begin
        next_hold_cnt = '0;
        if (!hold_cause)
          next_state = ST_HOLD; // RULE2 RULE11
      end
      ST_HOLD:
      begin
        if (hold_cause)
        begin
          next_state = ST_ACTIVE; // RULE13
          next_hold_cnt = '0;
        end
        else if (hold_cnt == HOLD_LAST)
        begin
          next_state = ST_RUN;
          next_cause = '0;
        end
        else
          next_hold_cnt = hold_cnt + 1'b1; // RULE18
      end
      ST_RUN:
      begin
        next_hold_cnt = '0;
        if (hold_cause)
          next_state = ST_ACTIVE; // RULE1 RULE11 RULE15
        else if (wdog_expire)
          next_state = ST_HOLD; // RULE5
      end
      default:
        next_state = ST_ACTIVE;
    endcase
    if (supply_low)
      next_cause.supply_low = 1'b1;
    if (!sync2[1])
      next_cause.manual = 1'b1;
    if (wdog_expire)
      next_cause.watchdog = 1'b1;
    // watchdog counter
    if (state != ST_RUN || kick_edge || wdog_expire)
      next_wdog_cnt = '0; // RULE6 RULE7 RULE8
    else
      next_wdog_cnt = wdog_cnt + 1'b1;
    // free-running internal driver, low 7/8 then high
    next_drv_cnt = (drv_cnt == WDOG_LAST) ? '0 : drv_cnt + 1'b1; // RULE9
    next_weak_drive = (next_drv_cnt >= DRV_HIGH_AT); // RULE9
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_ACTIVE;
      hold_cnt <= '0;
      wdog_cnt <= '0;
      drv_cnt <= '0;
      dip_cnt <= '0;
      kick_prev <= 1'b0;
      weak_drive <= 1'b0;
      cause <= '0;
    end
    else
    begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      wdog_cnt <= next_wdog_cnt;
      drv_cnt <= next_drv_cnt;
      dip_cnt <= next_dip_cnt;
      kick_prev <= sync2[2];
      weak_drive <= next_weak_drive;
      cause <= next_cause;
    end
  end

  assign rst_out = (state != ST_RUN);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      system_reset_n_output_o <= ACTIVE_HIGH;
      system_reset_n_output_oe_o <= 1'b1;
      reset_active_o <= 1'b1;
      cause_o <= '0;
    end
    else
    begin
      system_reset_n_output_o <= OPEN_DRAIN ? 1'b0 :
        (ACTIVE_HIGH ? rst_out : !rst_out); // RULE1 RULE18
      system_reset_n_output_oe_o <= OPEN_DRAIN ? rst_out : 1'b1; // RULE18
      reset_active_o <= rst_out;
      cause_o <= next_cause;
    end
  end

  AST_SUPPLY_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    supply_low |=> state == ST_ACTIVE ##1 reset_active_o) else $error("supply low without reset");
  AST_WDOG_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    (state != ST_RUN) |=> wdog_cnt == '0) else $error("watchdog counted during reset");
  AST_KICK_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    kick_edge |=> wdog_cnt == '0) else $error("kick did not clear counter");
  AST_WDOG_EXPIRE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    wdog_expire && !hold_cause |=> state == ST_HOLD && hold_cnt == '0)
    else $error("no reset on expiry");
  AST_HOLD_ADV: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    state == ST_HOLD && !hold_cause && hold_cnt != HOLD_LAST |=>
    state == ST_HOLD && hold_cnt == $past(hold_cnt) + 1'b1)
    else $error("hold period cut short");
  AST_MANUAL: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    !sync2[1] |=> state == ST_ACTIVE) else $error("manual reset ignored");
  AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    $rose(state == ST_RUN) |-> wdog_cnt == '0) else $error("counter not cleared at release");
  AST_DRIVER: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    drv_cnt < DRV_HIGH_AT |-> !weak_drive) else $error("driver high too early");
  AST_OUT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
    reset_active_o == $past(rst_out)) else $error("output not following reset state");
  COV_WDOG: cover property (@(posedge clk_i) wdog_expire);
  COV_MANUAL: cover property (@(posedge clk_i) $fell(sync2[1]));
  COV_RELEASE: cover property (@(posedge clk_i) $rose(state == ST_RUN));
endmodule

// ### verif/host_model.sv
// host side: services the kick pin at a set gap or leaves it floating
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic float_i,
  input wire logic [15:0] gap_i,
  output logic kick_o,
  output logic kick_oe_o
);
  int cnt = 0;
  initial
  begin
    kick_o = 1'b0;
    kick_oe_o = 1'b1;
  end
  always @(negedge clk_i)
  begin
    kick_oe_o <= !float_i;
    cnt <= (run_i && cnt < gap_i) ? cnt + 1 : 0;
    if (float_i && kick_oe_o)
      kick_o <= !kick_o; // released line shows inverse of last value
    else if (run_i && !float_i && cnt >= gap_i)
      kick_o <= !kick_o;
  end
endmodule

// ### verif/testbench.sv
// supervisor bench: scenario driver, reset-episode monitor, verdict
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 200;
  localparam int WDOG = 800;
  typedef struct {supervisor_pkg::reset_cause_s cause; int min_gap; int rel;} note_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sup = 1'b0;
  logic mr_n = 1'b1;
  logic mr_oe = 1'b1;
  logic run = 1'b1;
  logic flt = 1'b0;
  logic [15:0] gap = 16'h0064;
  logic kick, kick_oe, pin, act, prev = 1'b0;
  logic pin_oe;
  supervisor_pkg::reset_cause_s cause, seen = '0;
  note_s q[$];
  note_s nt;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int fall_c = 0;
  int seed = 32'hc2fa48b5;
  always #10 clk_i = ~clk_i;
  host_model host_u (.clk_i(clk_i), .run_i(run), .float_i(flt), .gap_i(gap), .kick_o(kick),
    .kick_oe_o(kick_oe));
  supervisor_watchdog_reset #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .supply_low_i(sup), .manual_reset_n_input_i(mr_n),
    .manual_reset_n_input_oe_i(mr_oe), .watchdog_kick_input_i(kick),
    .watchdog_kick_input_oe_i(kick_oe), .system_reset_n_output_o(pin),
    .system_reset_n_output_oe_o(pin_oe), .reset_active_o(act), .cause_o(cause));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_act(input logic lvl, input int lim);
    for (int i = 0; i < lim && act !== lvl; i++)
      @(negedge clk_i);
    chk("reset_active", lvl, act);
    if (act !== lvl)
      final_report();
  endtask
  task automatic expect_rst(input logic [2:0] c, input int g);
    q.push_back('{supervisor_pkg::reset_cause_s'(c), g, 0});
  endtask
  // one note per reset episode, checked at its rise and fall
  always @(posedge clk_i)
  begin
    #1 cyc++;
    if (act === 1'b1)
      seen = seen | cause;
    if (act === 1'b1 && !prev)
    begin
      chk("pin_at_rise", 0, pin);
      chk("pin_oe", 1, pin_oe);
      if (q.size() == 0)
        chk("unexpected_reset", 0, 1);
      else
        chk("gap_ok", 1, cyc - fall_c >= q[0].min_gap);
    end
    if (act === 1'b0 && prev && q.size() > 0)
    begin
      nt = q.pop_front();
      chk("cause", nt.cause, seen);
      chk("pin_at_fall", 1, pin);
      if (nt.rel > 0)
        chk("hold_len", 1, cyc - nt.rel >= HOLD && cyc - nt.rel <= HOLD + 8);
      seen = '0;
      fall_c = cyc;
    end
    prev = (act === 1'b1);
  end
  initial
  begin
    expect_rst(3'b000, 0);
    idle(6);
    rst_i = 1'b0;
    wait_act(0, HOLD + 20);
    for (int i = 0; i < 4; i++)
    begin
      gap = 16'($unsigned($random(seed)) % 700 + 50);
      idle(2000);
    end
    expect_rst(3'b010, 0);
    mr_n = 1'b0;
    wait_act(1, 10);
    for (int i = 0; i < 4; i++)
    begin
      mr_n = ~mr_n;
      idle(20 + i * 30);
    end
    mr_n = 1'b1;
    q[$].rel = cyc;
    wait_act(0, HOLD + 20);
    mr_oe = 1'b0;
    mr_n = 1'b0;
    idle(300);
    mr_oe = 1'b1;
    mr_n = 1'b1;
    sup = 1'b1;
    idle(2000 + $unsigned($random(seed)) % 700);
    sup = 1'b0;
    idle(50);
    expect_rst(3'b100, 0);
    sup = 1'b1;
    wait_act(1, 2800);
    run = 1'b0;
    idle(50);
    sup = 1'b0;
    q[$].rel = cyc;
    wait_act(0, HOLD + 20);
    for (int i = 0; i < 2; i++)
    begin
      expect_rst(3'b001, WDOG - 2);
      wait_act(1, WDOG + 20);
      q[$].rel = cyc;
      wait_act(0, HOLD + 20);
    end
    flt = 1'b1;
    idle(5 * WDOG);
    chk("notes_left", 0, q.size());
    final_report();
  end
endmodule
